// *** hw/bank_window.sv ***
// address window of one flash bank: span code and base to hit and offset
// assumes a word address on its input
module bank_window
	import flash_cmd_pkg::*;
#(
	parameter int GRANULE_SHIFT = PRIMARY_GRANULE_SHIFT,
	parameter logic [3:0] SPAN_MAX = PRIMARY_SPAN_MAX
)
(
	input wire logic [23:0] word_addr_i,
	input wire logic [3:0] span_i,
	input wire logic [23:0] base_i,
	output logic hit_o,
	output logic [23:0] offset_o
);
	if (GRANULE_SHIFT + int'(SPAN_MAX) > FLASH_ADDR_W)
	begin : g_bad_span
		$error("bank_window: largest span exceeds the flash address space");
	end

	// window in words is two to the power of granule plus span
	wire logic [4:0] shift = 5'(GRANULE_SHIFT) + {1'b0, span_i};
	wire logic [23:0] mask = (24'h000001 << shift) - 24'h000001;
	wire logic span_legal = span_i <= SPAN_MAX;

	assign hit_o = span_legal && ((word_addr_i & ~mask) == (base_i & ~mask));
	assign offset_o = word_addr_i & mask;
endmodule // bank_window

// *** hw/flash_bus_if.sv ***
// memory bus between the command-issuing host and the flash device
// assumes both parties sit on the same clock
interface flash_bus_if;
	logic [31:0] bus_addr;
	logic [31:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] bus_rdata;
	modport device (input bus_addr, input bus_wdata, input bus_wr, input bus_rd, output bus_rdata);
	modport host (output bus_addr, output bus_wdata, output bus_wr, output bus_rd, input bus_rdata);
endinterface

// *** hw/flash_cmd_pkg.sv ***
// constants and types shared by both ends of the flash command link
// assumes one 250 MHz clock on both ends
package flash_cmd_pkg;
	// --------------------------------------------------------------
	// command bytes
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_ARRAY_READ = 8'hff;
	localparam logic [7:0] CMD_STATUS_READ = 8'h70;
	localparam logic [7:0] CMD_SIGNATURE_READ = 8'h90;
	localparam logic [7:0] CMD_OTP_READ = 8'h98;
	localparam logic [7:0] CMD_STATUS_CLEAR = 8'h50;
	localparam logic [7:0] CMD_BLOCK_WIPE = 8'h20;
	localparam logic [7:0] CMD_BANK_WIPE = 8'h80;
	localparam logic [7:0] CMD_HALFWORD_WRITE = 8'h40;
	localparam logic [7:0] CMD_OPERATION_PAUSE = 8'hb0;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_GUARD_SETUP = 8'h60;
	localparam logic [7:0] CMD_GUARD = 8'h01;
	localparam logic [7:0] CMD_CONFIG = 8'h03;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
	localparam logic [7:0] OTP_FREEZE_DATA = 8'h01;
	// --------------------------------------------------------------
	// bank map registers and address layout
	// --------------------------------------------------------------
	localparam logic [31:0] PRIMARY_SPAN_ADDR = 32'h54000000;
	localparam logic [31:0] SECONDARY_SPAN_ADDR = 32'h54000004;
	localparam logic [31:0] PRIMARY_BASE_ADDR = 32'h5400000c;
	localparam logic [7:0] REG_SPACE_TAG = 8'h54;
	localparam logic [3:0] SPAN_RESET = 4'h0;
	localparam logic [23:0] BASE_RESET = 24'h000000;
	localparam logic [3:0] PRIMARY_SPAN_MAX = 4'hb;
	localparam logic [3:0] SECONDARY_SPAN_MAX = 4'hd;
	localparam int PRIMARY_GRANULE_SHIFT = 13;
	localparam int SECONDARY_GRANULE_SHIFT = 11;
	localparam int FLASH_ADDR_W = 24;
	// --------------------------------------------------------------
	// status, signature and otp layout
	// --------------------------------------------------------------
	localparam int ST_READY = 7;
	localparam int ST_ERASE_PAUSED = 6;
	localparam int ST_PROG_PAUSED = 2;
	localparam int ST_GUARD_ERR = 1;
	localparam logic [23:0] SIG_ID_IDX = 24'h000000;
	localparam logic [23:0] SIG_GUARD_IDX = 24'h000001;
	localparam logic [23:0] SIG_CONFIG_IDX = 24'h000002;
	localparam int OTP_WORDS = 8;
	localparam logic [23:0] OTP_FREEZE_IDX = 24'h000008;
	localparam logic [15:0] CONFIG_RESET = 16'h0000;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int PROG_TIME_NS = 40;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// --------------------------------------------------------------
	// host command port
	// --------------------------------------------------------------
	localparam logic [2:0] HOST_TARGET_OFF = 3'h0;
	localparam logic [2:0] HOST_DATA_OFF = 3'h1;
	localparam logic [2:0] HOST_GO_OFF = 3'h2;
	localparam logic [2:0] HOST_RESULT_OFF = 3'h3;
	localparam logic [2:0] HOST_STATUS_OFF = 3'h4;
	localparam int GO_WRITE_BIT = 0;
	localparam int GO_READ_BIT = 1;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ARRAY = 2'b00,
		MODE_STATUS = 2'b01,
		MODE_SIGNATURE = 2'b10,
		MODE_OTP = 2'b11
	} read_mode_type;
	typedef enum logic [2:0] {
		SEQ_NONE = 3'b000,
		SEQ_WIPE_BLOCK = 3'b001,
		SEQ_WIPE_BANK = 3'b010,
		SEQ_HALFWORD = 3'b011,
		SEQ_GUARD = 3'b100,
		SEQ_OTP = 3'b101
	} seq_type;
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_PROG = 2'b01,
		ENG_WIPE = 2'b10
	} engine_type;
endpackage

// *** hw/flash_device_end.sv ***
// command front end and bank map of a two-bank flash, with a small array model
// assumes the host keeps one strobe per cycle and the banks apart
//
// What this block does
// - cpu address bits 25:2 form flash word address
// - command byte travels on data bits 7:0
// - commands at word addresses, halfword data excepted
// - ffh puts bank into array read
// - 70h makes bank reads return status
// - 50h clears the bank status
// - 90h/98h to bank 1 enter signature/otp read
// - block wipe is 20h then d0h same sector
// - bank wipe is 80h then d0h same bank
// - halfword write is 40h then halfword value
// - b0h pauses running operation in that bank
// - d0h to paused bank resumes the operation
// - 60h then 01h guards, d0h unguards sector
// - 60h to bank 1 then 03h writes config
// - c0h then otp word, or 01h at 08h freezes
// - software keeps the two bank windows apart
// - bank 0 primary by default, software sizes both windows, places only primary
// - test port swaps which bank is primary
// - primary span is 32 KB shifted, codes to 1011
// - secondary span is 8 KB shifted, codes to 1101
// - primary base is 24-bit word address, resets zero
// - software aligns a relocated base to its span
// - status bit 7 low while that bank's engine runs unpaused
//
// Design decision made here: the address-and-strobe port.
module flash_device_end
	import flash_cmd_pkg::*;
#(
	parameter int BANK_WORDS = 256,
	parameter int SECTOR_WORDS = 64,
	parameter logic [23:0] SECONDARY_BASE = 24'h020000,
	parameter logic [31:0] ID_VALUE = 32'h0000a5c3 // arbitrary value
)
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	flash_bus_if.device bus,
	input wire logic boot_bank1_i,
	output logic engine_busy_o
);
	localparam int AW = $clog2(BANK_WORDS);
	localparam int SW = $clog2(SECTOR_WORDS);
	localparam int SECTORS = BANK_WORDS / SECTOR_WORDS;
	if (SECTOR_WORDS < OTP_WORDS * 2 || BANK_WORDS < SECTOR_WORDS * 2 || (1 << AW) != BANK_WORDS
		|| (1 << SW) != SECTOR_WORDS || AW > FLASH_ADDR_W)
	begin : g_bad_size
		$error("flash_device_end: bank and sector sizes must be powers of two");
	end

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [31:0] mem [2][BANK_WORDS];
	logic [31:0] otp_reg [OTP_WORDS];
	logic otp_frozen_reg;
	logic [15:0] config_reg;
	logic [1:0][SECTORS-1:0] guard_reg;
	logic [1:0] guard_err_reg;
	read_mode_type mode_reg [2];
	logic [3:0] prim_span_reg;
	logic [3:0] sec_span_reg;
	logic [23:0] prim_base_reg;
	logic boot_meta_reg, boot_s2_reg, boot_s3_reg, boot_bank1_reg;
	seq_type seq_reg;
	logic seq_bank_reg;
	logic [23:0] seq_off_reg;
	engine_type eng_reg;
	logic eng_bank_reg;
	logic eng_paused_reg;
	logic [AW-1:0] eng_cursor_reg;
	logic [AW-1:0] eng_last_reg;
	logic [7:0] eng_count_reg;
	logic [31:0] eng_data_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	seq_type seq_next;
	logic [7:0] status_sel;

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	wire logic reg_space = bus.bus_addr[31:24] == REG_SPACE_TAG;
	wire logic [23:0] word_addr = bus.bus_addr[25:2];
	wire logic prim_hit, sec_hit;
	wire logic [23:0] prim_off, sec_off;

	bank_window #(.GRANULE_SHIFT(PRIMARY_GRANULE_SHIFT), .SPAN_MAX(PRIMARY_SPAN_MAX)) u_prim (
		.word_addr_i(word_addr),
		.span_i(prim_span_reg),
		.base_i(prim_base_reg),
		.hit_o(prim_hit),
		.offset_o(prim_off)
	);
	bank_window #(.GRANULE_SHIFT(SECONDARY_GRANULE_SHIFT), .SPAN_MAX(SECONDARY_SPAN_MAX)) u_sec (
		.word_addr_i(word_addr),
		.span_i(sec_span_reg),
		.base_i(SECONDARY_BASE),
		.hit_o(sec_hit),
		.offset_o(sec_off)
	);

	// primary window wins if software lets the windows overlap
	wire logic any_hit = !reg_space && (prim_hit || sec_hit);
	wire logic bank = prim_hit ? boot_bank1_reg : !boot_bank1_reg;
	wire logic [23:0] off = prim_hit ? prim_off : sec_off;
	wire logic [AW-1:0] idx = off[AW-1:0];
	wire logic [AW-SW-1:0] sect = idx[AW-1:SW];
	wire logic [7:0] cmd = bus.bus_wdata[7:0];
	wire logic [15:0] half = bus.bus_addr[1] ? bus.bus_wdata[31:16] : bus.bus_wdata[15:0];

	// --------------------------------------------------------------
	// command events
	// --------------------------------------------------------------
	wire logic wr_flash = bus.bus_wr && any_hit;
	wire logic first = wr_flash && seq_reg == SEQ_NONE;
	wire logic second = wr_flash && seq_reg != SEQ_NONE;
	wire logic same_bank = bank == seq_bank_reg;
	wire logic same_sector = same_bank && (off >> SW) == (seq_off_reg >> SW);
	wire logic guarded = guard_reg[bank][sect];
	wire logic bank_guarded = |guard_reg[bank];
	wire logic eng_free = eng_reg == ENG_IDLE;
	wire logic confirm = cmd == CMD_CONFIRM;
	wire logic try_block = second && seq_reg == SEQ_WIPE_BLOCK && confirm && same_sector;
	wire logic try_bank = second && seq_reg == SEQ_WIPE_BANK && confirm && same_bank;
	wire logic try_prog = second && seq_reg == SEQ_HALFWORD;
	wire logic guard_fail = ((try_block || try_prog) && guarded) || (try_bank && bank_guarded);
	wire logic start_block = try_block && eng_free && !guarded;
	wire logic start_bank = try_bank && eng_free && !bank_guarded;
	wire logic start_prog = try_prog && eng_free && !guarded;
	wire logic guard_op = second && seq_reg == SEQ_GUARD && same_sector;
	wire logic guard_set = guard_op && cmd == CMD_GUARD;
	wire logic guard_clr = guard_op && confirm;
	wire logic config_set = second && seq_reg == SEQ_GUARD && bank && seq_bank_reg
		&& cmd == CMD_CONFIG;
	wire logic otp_op = second && seq_reg == SEQ_OTP && bank;
	wire logic otp_prog = otp_op && off < 24'(OTP_WORDS) && !otp_frozen_reg;
	wire logic otp_freeze = otp_op && off == OTP_FREEZE_IDX && cmd == OTP_FREEZE_DATA;
	wire logic sel_busy = !eng_free && eng_bank_reg == bank;
	wire logic pause = first && cmd == CMD_OPERATION_PAUSE && sel_busy && !eng_paused_reg;
	wire logic resume = first && confirm && sel_busy && eng_paused_reg;
	wire logic to_status = start_block || start_bank || start_prog || resume;

	always_comb
	begin
		seq_next = SEQ_NONE;
		if (first)
		begin
			unique case (cmd)
				CMD_BLOCK_WIPE: seq_next = SEQ_WIPE_BLOCK;
				CMD_BANK_WIPE: seq_next = SEQ_WIPE_BANK;
				CMD_HALFWORD_WRITE: seq_next = SEQ_HALFWORD;
				CMD_GUARD_SETUP: seq_next = SEQ_GUARD;
				CMD_OTP_SETUP: seq_next = bank ? SEQ_OTP : SEQ_NONE;
				default: seq_next = SEQ_NONE;
			endcase
		end
		else if (!second)
			seq_next = seq_reg;
	end

	// --------------------------------------------------------------
	// write/erase engine
	// --------------------------------------------------------------
	wire logic eng_run = !eng_free && !eng_paused_reg;
	wire logic prog_done = eng_run && eng_reg == ENG_PROG && eng_count_reg == 8'h00;
	wire logic wipe_step = eng_run && eng_reg == ENG_WIPE;
	wire logic [31:0] mem_wdata = prog_done ? mem[eng_bank_reg][eng_cursor_reg] & eng_data_reg
		: 32'hffffffff;

	always_ff @(posedge sys_clk_i)
		if (prog_done || wipe_step)
			mem[eng_bank_reg][eng_cursor_reg] <= mem_wdata;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			eng_reg <= ENG_IDLE;
			eng_bank_reg <= 1'b0;
			eng_paused_reg <= 1'b0;
			eng_cursor_reg <= '0;
			eng_last_reg <= '0;
			eng_count_reg <= 8'h00;
			eng_data_reg <= 32'hffffffff;
		end
		else
		begin
			if (start_prog)
			begin
				eng_reg <= ENG_PROG;
				eng_cursor_reg <= idx;
				eng_count_reg <= 8'(PROG_CYCLES - 1);
				eng_data_reg <= bus.bus_addr[1] ? {half, 16'hffff} : {16'hffff, half};
			end
			else if (start_block || start_bank)
			begin
				eng_reg <= ENG_WIPE;
				eng_cursor_reg <= start_bank ? '0 : {sect, {SW{1'b0}}};
				eng_last_reg <= start_bank ? '1 : {sect, {SW{1'b1}}};
			end
			else if (prog_done || (wipe_step && eng_cursor_reg == eng_last_reg))
				eng_reg <= ENG_IDLE;
			else if (wipe_step)
				eng_cursor_reg <= eng_cursor_reg + AW'(1);
			else if (eng_run)
				eng_count_reg <= eng_count_reg - 8'h01;
			if (start_prog || start_block || start_bank)
				eng_bank_reg <= bank;
			if (pause || resume)
				eng_paused_reg <= pause;
		end
	end

	// --------------------------------------------------------------
	// command state, protection, otp and config
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			seq_reg <= SEQ_NONE;
			seq_bank_reg <= 1'b0;
			seq_off_reg <= 24'h000000;
			mode_reg <= '{MODE_ARRAY, MODE_ARRAY};
			guard_reg <= '0;
			guard_err_reg <= 2'b00;
			otp_frozen_reg <= 1'b0;
			config_reg <= CONFIG_RESET;
		end
		else
		begin
			seq_reg <= seq_next;
			if (first)
			begin
				seq_bank_reg <= bank;
				seq_off_reg <= off;
			end
			if (first && cmd == CMD_ARRAY_READ)
				mode_reg[bank] <= MODE_ARRAY;
			else if ((first && cmd == CMD_STATUS_READ) || to_status)
				mode_reg[bank] <= MODE_STATUS;
			else if (first && bank && cmd == CMD_SIGNATURE_READ)
				mode_reg[bank] <= MODE_SIGNATURE;
			else if (first && bank && cmd == CMD_OTP_READ)
				mode_reg[bank] <= MODE_OTP;
			if (guard_fail)
				guard_err_reg[bank] <= 1'b1;
			else if (first && cmd == CMD_STATUS_CLEAR)
				guard_err_reg[bank] <= 1'b0;
			if (guard_set || guard_clr)
				guard_reg[bank][sect] <= guard_set;
			if (config_set)
				config_reg <= off[15:0];
			if (otp_freeze)
				otp_frozen_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
		if (otp_prog)
			otp_reg[off[2:0]] <= otp_reg[off[2:0]] & bus.bus_wdata;

	// --------------------------------------------------------------
	// bank map registers and test port
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			prim_span_reg <= SPAN_RESET;
			sec_span_reg <= SPAN_RESET;
			prim_base_reg <= BASE_RESET;
			boot_meta_reg <= 1'b0;
			boot_s2_reg <= 1'b0;
			boot_s3_reg <= 1'b0;
			boot_bank1_reg <= 1'b0;
		end
		else
		begin
			if (bus.bus_wr && bus.bus_addr == PRIMARY_SPAN_ADDR)
				prim_span_reg <= bus.bus_wdata[3:0];
			if (bus.bus_wr && bus.bus_addr == SECONDARY_SPAN_ADDR)
				sec_span_reg <= bus.bus_wdata[3:0];
			if (bus.bus_wr && bus.bus_addr == PRIMARY_BASE_ADDR)
				prim_base_reg <= bus.bus_wdata[23:0];
			boot_meta_reg <= boot_bank1_i;
			boot_s2_reg <= boot_meta_reg;
			boot_s3_reg <= boot_s2_reg;
			if (boot_s2_reg == boot_s3_reg)
				boot_bank1_reg <= boot_s3_reg;
		end
	end

	// --------------------------------------------------------------
	// read path, one cycle after the read strobe
	// --------------------------------------------------------------
	always_comb
	begin
		status_sel = 8'h00;
		status_sel[ST_READY] = !(sel_busy && !eng_paused_reg);
		status_sel[ST_ERASE_PAUSED] = sel_busy && eng_paused_reg && eng_reg == ENG_WIPE;
		status_sel[ST_PROG_PAUSED] = sel_busy && eng_paused_reg && eng_reg == ENG_PROG;
		status_sel[ST_GUARD_ERR] = guard_err_reg[bank];
	end

	always_comb
	begin
		rdata_next = 32'h00000000;
		if (bus.bus_addr == PRIMARY_SPAN_ADDR)
			rdata_next = {28'h0000000, prim_span_reg};
		else if (bus.bus_addr == SECONDARY_SPAN_ADDR)
			rdata_next = {28'h0000000, sec_span_reg};
		else if (bus.bus_addr == PRIMARY_BASE_ADDR)
			rdata_next = {8'h00, prim_base_reg};
		else if (any_hit)
		begin
			unique case (mode_reg[bank])
				MODE_ARRAY: rdata_next = mem[bank][idx];
				MODE_STATUS: rdata_next = {24'h000000, status_sel};
				MODE_SIGNATURE:
					if (off == SIG_ID_IDX)
						rdata_next = ID_VALUE;
					else if (off == SIG_GUARD_IDX)
						rdata_next = 32'(guard_reg);
					else if (off == SIG_CONFIG_IDX)
						rdata_next = {16'h0000, config_reg};
				MODE_OTP:
					if (off < 24'(OTP_WORDS))
						rdata_next = otp_reg[off[2:0]];
					else if (off == OTP_FREEZE_IDX)
						rdata_next = {31'h00000000, otp_frozen_reg};
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
		if (reset_i)
			rdata_reg <= 32'h00000000;
		else if (bus.bus_rd)
			rdata_reg <= rdata_next;

	assign bus.bus_rdata = rdata_reg;
	assign engine_busy_o = !eng_free;
endmodule // flash_device_end

// *** hw/flash_host_end.sv ***
// host end: turns software orders into single memory bus cycles
// assumes software waits for the busy bit before the next order
module flash_host_end
	import flash_cmd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	flash_bus_if.host bus,
	input wire logic [2:0] sw_addr_i,
	input wire logic [31:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [31:0] sw_rdata_o
);
	logic [31:0] target_reg, data_reg, result_reg, sw_rdata_reg;
	logic [31:0] bus_addr_reg, bus_wdata_reg;
	logic bus_wr_reg, bus_rd_reg, capture_reg;
	logic [31:0] sw_rdata_next;

	wire logic busy = bus_wr_reg || bus_rd_reg || capture_reg;
	wire logic go = sw_wr_i && sw_addr_i == HOST_GO_OFF && !busy;
	// write wins so that the two bus strobes never rise together
	wire logic go_wr = go && sw_wdata_i[GO_WRITE_BIT];
	wire logic go_rd = go && !sw_wdata_i[GO_WRITE_BIT] && sw_wdata_i[GO_READ_BIT];

	always_comb
	begin
		unique case (sw_addr_i)
			HOST_TARGET_OFF: sw_rdata_next = target_reg;
			HOST_DATA_OFF: sw_rdata_next = data_reg;
			HOST_RESULT_OFF: sw_rdata_next = result_reg;
			HOST_STATUS_OFF: sw_rdata_next = {31'h00000000, busy};
			default: sw_rdata_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			target_reg <= 32'h00000000;
			data_reg <= 32'h00000000;
			result_reg <= 32'h00000000;
			sw_rdata_reg <= 32'h00000000;
			bus_addr_reg <= 32'h00000000;
			bus_wdata_reg <= 32'h00000000;
			bus_wr_reg <= 1'b0;
			bus_rd_reg <= 1'b0;
			capture_reg <= 1'b0;
		end
		else
		begin
			if (sw_wr_i && sw_addr_i == HOST_TARGET_OFF)
				target_reg <= sw_wdata_i;
			if (sw_wr_i && sw_addr_i == HOST_DATA_OFF)
				data_reg <= sw_wdata_i;
			if (sw_rd_i)
				sw_rdata_reg <= sw_rdata_next;
			bus_wr_reg <= go_wr;
			bus_rd_reg <= go_rd;
			capture_reg <= bus_rd_reg;
			if (go)
			begin
				bus_addr_reg <= {target_reg[31:1], 1'b0};
				bus_wdata_reg <= data_reg;
			end
			if (capture_reg)
				result_reg <= bus.bus_rdata;
		end
	end

	assign bus.bus_addr = bus_addr_reg;
	assign bus.bus_wdata = bus_wdata_reg;
	assign bus.bus_wr = bus_wr_reg;
	assign bus.bus_rd = bus_rd_reg;
	assign sw_rdata_o = sw_rdata_reg;
endmodule // flash_host_end

// *** tb/flash_cmd_chk.sv ***
// checker for the memory bus joining the host end to the device end
// assumes the bench instantiates it beside the interface, joined by name
module flash_cmd_chk
	import flash_cmd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic engine_busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// ----
	// length of the current engine operation
	// ----
	logic [9:0] busy_cnt_reg;
	logic [9:0] busy_cnt_next;
	assign busy_cnt_next = engine_busy_o ? busy_cnt_reg + 10'h001 : 10'h000;
	always_ff @(posedge sys_clk_i)
	begin
		busy_cnt_reg <= reset_i ? 10'h000 : busy_cnt_next;
	end
	sequence reg_read;
		bus_rd && bus_addr[31:24] == REG_SPACE_TAG;
	endsequence
	sequence busy_start;
		$rose(engine_busy_o);
	endsequence
	// ----
	// assertions
	// ----
	addr_align_a: assert property (bus_wr |-> !bus_addr[0])
		else $error("odd byte address on a bus write");
	write_pulse_a: assert property (bus_wr |-> !bus_rd ##1 !bus_wr)
		else $error("write strobe longer than one cycle");
	read_pulse_a: assert property (bus_rd |=> !bus_rd)
		else $error("read strobe longer than one cycle");
	rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
		else $error("read data moved without a read");
	reg_reserved_a: assert property (reg_read |=> bus_rdata[31:24] == 8'h00)
		else $error("reserved register bits read nonzero");
	span_reserved_a: assert property (bus_rd && (bus_addr == PRIMARY_SPAN_ADDR ||
		bus_addr == SECONDARY_SPAN_ADDR) |=> bus_rdata[31:4] == 28'h0)
		else $error("span register upper bits nonzero");
	busy_cause_a: assert property (busy_start |-> $past(bus_wr))
		else $error("engine started without a bus write");
	busy_min_a: assert property ($fell(engine_busy_o) |-> busy_cnt_reg >= 10'h008)
		else $error("engine operation too short");
endmodule // flash_cmd_chk

// *** tb/flash_command_and_bank_map_tb.sv ***
// self-checking bench: host end and device end joined by the memory bus
// assumes package, interface and both ends are compiled before it
module flash_command_and_bank_map_tb
	import flash_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0] kind;
		logic [31:0] addr;
		logic [31:0] data;
		logic [31:0] mask;
	} row_type;
	localparam logic [31:0] B1 = 32'h00080000;
	localparam logic [31:0] F = 32'hffffffff;
	localparam logic [31:0] S = 32'h000000ff;
	localparam logic [31:0] PS = PRIMARY_SPAN_ADDR;
	localparam logic [31:0] SS = SECONDARY_SPAN_ADDR;
	localparam logic [31:0] PB = PRIMARY_BASE_ADDR;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic boot_bank1_i = 1'b0;
	logic [2:0] sw_addr_i = 3'h0;
	logic [31:0] sw_wdata_i = 32'h0;
	logic sw_wr_i = 1'b0;
	logic sw_rd_i = 1'b0;
	logic [31:0] sw_rdata_o;
	logic engine_busy_o;
	int miscompares = 0;
	int cmp_count = 0;
	row_type rows [$];
	flash_bus_if bus_link();
	flash_host_end flash_host_end_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .bus(bus_link),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o));
	flash_device_end #(.SECONDARY_BASE(24'h020000)) flash_device_end_i (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .bus(bus_link), .boot_bank1_i(boot_bank1_i),
		.engine_busy_o(engine_busy_o));
	flash_cmd_chk flash_cmd_chk_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.bus_addr(bus_link.bus_addr), .bus_wdata(bus_link.bus_wdata), .bus_wr(bus_link.bus_wr),
		.bus_rd(bus_link.bus_rd), .bus_rdata(bus_link.bus_rdata), .engine_busy_o(engine_busy_o));
	always #2 sys_clk_i = ~sys_clk_i;
	// ----
	// row builders and software port tasks
	// ----
	function automatic row_type cmd(input logic [31:0] a, input logic [7:0] d);
		return '{2'h0, a, {24'h0, d}, 32'h0};
	endfunction
	function automatic row_type dat(input logic [31:0] a, input logic [31:0] d);
		return '{2'h0, a, d, 32'h0};
	endfunction
	function automatic row_type rdx(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		return '{2'h1, a, e, m};
	endfunction
	function automatic row_type idle(input logic chk);
		return '{2'h2, 32'h0, {31'h0, chk}, 32'h0};
	endfunction
	task automatic compare(input logic [31:0] a, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH read of %h expected %h seen %h", a, e, s);
		end
	endtask
	task automatic sw(input logic [2:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		sw_wr_i <= 1'b0;
	endtask
	task automatic sw_rd(input logic [2:0] a, output logic [31:0] v);
		@(posedge sys_clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		sw_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		v = sw_rdata_o;
	endtask
	task automatic step(input row_type t);
		logic [31:0] v;
		if (t.kind == 2'h2)
		begin
			if (t.data[0])
				compare(t.addr, 32'h1, {31'h0, engine_busy_o});
			for (int n = 0; n < 400 && engine_busy_o !== 1'b0; n++)
				@(negedge sys_clk_i);
			if (engine_busy_o !== 1'b0)
			begin
				miscompares++;
				$display("MISMATCH engine idle expected 0 seen %b", engine_busy_o);
			end
		end
		else
		begin
			sw(HOST_TARGET_OFF, t.addr);
			sw(HOST_DATA_OFF, t.data);
			sw(HOST_GO_OFF, {30'h0, t.kind == 2'h1, t.kind == 2'h0});
			do
				sw_rd(HOST_STATUS_OFF, v);
			while (v[0] !== 1'b0);
			if (t.kind == 2'h1)
			begin
				sw_rd(HOST_RESULT_OFF, v);
				compare(t.addr, t.data, v & t.mask);
			end
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		miscompares++;
		complete_run();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rows = {rdx(PS, 32'h0, F), rdx(SS, 32'h0, F), rdx(PB, 32'h0, F),
			dat(PS, F), rdx(PS, 32'hf, F), dat(SS, 32'h12345673), rdx(SS, 32'h3, F),
			dat(PB, 32'hffabcdef), rdx(PB, 32'h00abcdef, F),
			dat(32'h54000008, F), rdx(32'h54000008, 32'h0, F),
			dat(PS, 32'h0), dat(PB, 32'h0), dat(SS, 32'h0),
			cmd(32'h0, CMD_BANK_WIPE), cmd(32'h0, CMD_CONFIRM), idle(1'b1),
			rdx(32'h0, 32'h80, S), cmd(32'h0, CMD_ARRAY_READ), rdx(32'h14, F, F),
			cmd(32'h14, CMD_HALFWORD_WRITE), dat(32'h16, 32'h12340000), idle(1'b0),
			cmd(32'h0, CMD_ARRAY_READ), rdx(32'h14, 32'h1234ffff, F),
			cmd(B1, CMD_BLOCK_WIPE), cmd(B1, CMD_CONFIRM), rdx(B1, 32'h0, S),
			cmd(B1, CMD_OPERATION_PAUSE), rdx(B1, 32'hc0, S),
			cmd(B1, CMD_CONFIRM), rdx(B1, 32'h0, S), idle(1'b1), rdx(B1, 32'h80, S),
			cmd(B1, CMD_ARRAY_READ), rdx(B1 + 32'h8, F, F),
			cmd(32'h0, CMD_GUARD_SETUP), cmd(32'h0, CMD_GUARD),
			cmd(32'h0, CMD_HALFWORD_WRITE), dat(32'h4, 32'h0000beef),
			cmd(32'h0, CMD_STATUS_READ), rdx(32'h0, 32'h82, S),
			cmd(32'h0, CMD_STATUS_CLEAR), rdx(32'h0, 32'h80, S),
			cmd(32'h0, CMD_ARRAY_READ), rdx(32'h4, F, F),
			cmd(B1, CMD_SIGNATURE_READ), rdx(B1 + 32'h4, 32'h1, 32'h1),
			cmd(32'h0, CMD_GUARD_SETUP), cmd(32'h0, CMD_CONFIRM), rdx(B1 + 32'h4, 32'h0, S),
			cmd(32'h0, CMD_GUARD_SETUP), cmd(32'h0, 8'h55), rdx(B1 + 32'h4, 32'h0, S),
			cmd(B1, CMD_GUARD_SETUP), cmd(B1 + 32'ha8, CMD_CONFIG),
			cmd(B1, CMD_SIGNATURE_READ), rdx(B1 + 32'h8, 32'h2a, 32'hffff),
			cmd(B1, CMD_OTP_SETUP), dat(B1, 32'h0),
			cmd(B1, CMD_OTP_SETUP), dat(B1 + 32'h20, 32'h1),
			cmd(B1, CMD_OTP_READ), rdx(B1, 32'h0, F),
			rdx(B1 + 32'h20, 32'h1, 32'h1)};
		foreach (rows[i])
			step(rows[i]);
		@(posedge sys_clk_i);
		boot_bank1_i <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		step(cmd(32'h0, CMD_ARRAY_READ));
		step(cmd(B1, CMD_ARRAY_READ));
		step(rdx(32'h14, F, F));
		step(rdx(B1 + 32'h14, 32'h1234ffff, F));
		step(dat(PB, 32'h40));
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		boot_bank1_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		step(rdx(PB, 32'h0, F));
		complete_run();
	end
endmodule // flash_command_and_bank_map_tb
